// >>> inc/cisl_defs.vh
// Constants for the card interface select latch
//
// Notes on behaviour
// - Select high holds power command, voltage, clock ratio and reset values.
// - Select gates host communication only; card supply stays as commanded.
// - After reset supply is off and host lines are actively pulled high.
// - Power command falling edge turns supply on, drops active pull-ups.
// - Power command rising edge turns supply off, restores active pull-ups.
`ifndef CISL_DEFS_VH
`define CISL_DEFS_VH

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define CISL_RST_SELECT_N    1'h1
`define CISL_RST_POWER_CMD_N 1'h1
`define CISL_RST_SUPPLY_VOLTAGE_SEL0       1'h0
`define CISL_RST_SUPPLY_VOLTAGE_SEL1       1'h0
`define CISL_RST_RATIO1      1'h0
`define CISL_RST_RATIO2      1'h0
`define CISL_RST_CARD_RESET  1'h0
`define CISL_RST_SUPPLY      1'h0
`define CISL_RST_PULLUP      1'h1
`define CISL_RST_LINK_EN     1'h0

`endif

// >>> core/cisl_select_latch.v
// Select latch and host-side line control of the card interface
`timescale 1ns/1ps
`default_nettype none
`include "cisl_defs.vh"

// ----------------------------------------------------------------
// Two-stage synchroniser for one asynchronous pin
// ----------------------------------------------------------------

// Only the second stage is read by the logic beyond
module cisl_sync_bit #(
    parameter [0:0] RESET_VALUE = 1'h0
) (
    input  wire clk,
    input  wire rst,
    input  wire pin,
    output reg  synced
);

    reg first_stage;

    // First stage catches the pin, second one settles it
    always @(posedge clk) begin
        if (rst) begin
            first_stage <= RESET_VALUE;
            synced      <= RESET_VALUE;
        end else begin
            first_stage <= pin;
            synced      <= first_stage;
        end
    end

endmodule

// ----------------------------------------------------------------
// Select latch and line control
// ----------------------------------------------------------------

module cisl_select_latch (
    input  wire clk,
    input  wire rst,
    input  wire select_n,
    input  wire card_power_cmd_n,
    input  wire supply_voltage_sel0,
    input  wire supply_voltage_sel1,
    input  wire clock_ratio_sel1,
    input  wire clock_ratio_sel2,
    input  wire host_card_reset_in,
    output reg  held_power_cmd_n,
    output reg  held_voltage_sel0,
    output reg  held_voltage_sel1,
    output reg  held_ratio_sel1,
    output reg  held_ratio_sel2,
    output reg  held_card_reset,
    output reg  card_supply,
    output reg  host_link_enable,
    output reg  host_io_pullup_oe,
    output reg  host_aux_line1_pullup_oe,
    output reg  host_aux_line2_pullup_oe
);

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------

    // Settled copies of the asynchronous pins
    wire sync_select_n;
    wire sync_power_cmd_n;
    wire sync_voltage_sel0;
    wire sync_voltage_sel1;
    wire sync_ratio_sel1;
    wire sync_ratio_sel2;
    wire sync_card_reset;

    // Select resets high so nothing leaks through before settling
    cisl_sync_bit #(
        .RESET_VALUE (`CISL_RST_SELECT_N)
    ) sync_select_inst (
        .clk    (clk),
        .rst    (rst),
        .pin    (select_n),
        .synced (sync_select_n)
    );

    // Power command resets inactive, no false edge
    cisl_sync_bit #(
        .RESET_VALUE (`CISL_RST_POWER_CMD_N)
    ) sync_power_cmd_inst (
        .clk    (clk),
        .rst    (rst),
        .pin    (card_power_cmd_n),
        .synced (sync_power_cmd_n)
    );

    // Supply voltage select, low bit
    cisl_sync_bit #(
        .RESET_VALUE (`CISL_RST_SUPPLY_VOLTAGE_SEL0)
    ) sync_voltage0_inst (
        .clk    (clk),
        .rst    (rst),
        .pin    (supply_voltage_sel0),
        .synced (sync_voltage_sel0)
    );

    // Supply voltage select, high bit
    cisl_sync_bit #(
        .RESET_VALUE (`CISL_RST_SUPPLY_VOLTAGE_SEL1)
    ) sync_voltage1_inst (
        .clk    (clk),
        .rst    (rst),
        .pin    (supply_voltage_sel1),
        .synced (sync_voltage_sel1)
    );

    // Clock ratio select, first bit
    cisl_sync_bit #(
        .RESET_VALUE (`CISL_RST_RATIO1)
    ) sync_ratio1_inst (
        .clk    (clk),
        .rst    (rst),
        .pin    (clock_ratio_sel1),
        .synced (sync_ratio_sel1)
    );

    // Clock ratio select, second bit
    cisl_sync_bit #(
        .RESET_VALUE (`CISL_RST_RATIO2)
    ) sync_ratio2_inst (
        .clk    (clk),
        .rst    (rst),
        .pin    (clock_ratio_sel2),
        .synced (sync_ratio_sel2)
    );

    // Card reset request from the host
    cisl_sync_bit #(
        .RESET_VALUE (`CISL_RST_CARD_RESET)
    ) sync_card_reset_inst (
        .clk    (clk),
        .rst    (rst),
        .pin    (host_card_reset_in),
        .synced (sync_card_reset)
    );

    // ------------------------------------------------------------
    // Hold or follow the control pins
    // ------------------------------------------------------------

    reg next_held_power_cmd_n;
    reg next_held_voltage_sel0;
    reg next_held_voltage_sel1;
    reg next_held_ratio_sel1;
    reg next_held_ratio_sel2;
    reg next_held_card_reset;

    // Frozen while deselected, transparent while selected
    always @* begin
        next_held_power_cmd_n  = held_power_cmd_n;
        next_held_voltage_sel0 = held_voltage_sel0;
        next_held_voltage_sel1 = held_voltage_sel1;
        next_held_ratio_sel1   = held_ratio_sel1;
        next_held_ratio_sel2   = held_ratio_sel2;
        next_held_card_reset   = held_card_reset;
        if (!sync_select_n) begin
            next_held_power_cmd_n  = sync_power_cmd_n;
            next_held_voltage_sel0 = sync_voltage_sel0;
            next_held_voltage_sel1 = sync_voltage_sel1;
            next_held_ratio_sel1   = sync_ratio_sel1;
            next_held_ratio_sel2   = sync_ratio_sel2;
            next_held_card_reset   = sync_card_reset;
        end
    end

    // Held copies of the control pins
    always @(posedge clk) begin
        if (rst) begin
            held_power_cmd_n  <= `CISL_RST_POWER_CMD_N;
            held_voltage_sel0 <= `CISL_RST_SUPPLY_VOLTAGE_SEL0;
            held_voltage_sel1 <= `CISL_RST_SUPPLY_VOLTAGE_SEL1;
            held_ratio_sel1   <= `CISL_RST_RATIO1;
            held_ratio_sel2   <= `CISL_RST_RATIO2;
            held_card_reset   <= `CISL_RST_CARD_RESET;
        end else begin
            held_power_cmd_n  <= next_held_power_cmd_n;
            held_voltage_sel0 <= next_held_voltage_sel0;
            held_voltage_sel1 <= next_held_voltage_sel1;
            held_ratio_sel1   <= next_held_ratio_sel1;
            held_ratio_sel2   <= next_held_ratio_sel2;
            held_card_reset   <= next_held_card_reset;
        end
    end

    // ------------------------------------------------------------
    // Supply and active pull-up control
    // ------------------------------------------------------------

    reg  prev_cmd_n;
    reg  next_card_supply;
    reg  next_pullup_oe;
    reg  next_link_enable;
    wire cmd_fell;
    wire cmd_rose;

    // Edges of the held command, not of the raw pin
    assign cmd_fell = prev_cmd_n & ~held_power_cmd_n;
    assign cmd_rose = ~prev_cmd_n & held_power_cmd_n;

    // Supply and pull-ups change only on command edges
    always @* begin
        next_card_supply = card_supply;
        next_pullup_oe   = host_io_pullup_oe;
        next_link_enable = ~sync_select_n;
        if (cmd_fell) begin
            next_card_supply = 1'h1;
            next_pullup_oe   = 1'h0;
        end else if (cmd_rose) begin
            next_card_supply = 1'h0;
            next_pullup_oe   = 1'h1;
        end
    end

    // Supply off and lines pulled high out of reset
    always @(posedge clk) begin
        if (rst) begin
            prev_cmd_n               <= `CISL_RST_POWER_CMD_N;
            card_supply              <= `CISL_RST_SUPPLY;
            host_io_pullup_oe        <= `CISL_RST_PULLUP;
            host_aux_line1_pullup_oe <= `CISL_RST_PULLUP;
            host_aux_line2_pullup_oe <= `CISL_RST_PULLUP;
            host_link_enable         <= `CISL_RST_LINK_EN;
        end else begin
            prev_cmd_n               <= held_power_cmd_n;
            card_supply              <= next_card_supply;
            host_io_pullup_oe        <= next_pullup_oe;
            host_aux_line1_pullup_oe <= next_pullup_oe;
            host_aux_line2_pullup_oe <= next_pullup_oe;
            // Select gates talk only, never the supply
            host_link_enable         <= next_link_enable;
        end
    end

endmodule
`default_nettype wire

// >>> tb/cisl_checker.sv
// Select latch checker
`timescale 1ns/1ps
`default_nettype none
module cisl_checker (input wire logic clk, rst, select_n, card_power_cmd_n,
    held_power_cmd_n, card_supply, host_link_enable, host_io_pullup_oe);
default clocking @(posedge clk); endclocking
default disable iff (rst);
a_hold_high: assert property (select_n[*3] |=>
    $stable(held_power_cmd_n)) else $error("held moved");
a_follow_low: assert property (!$past(select_n, 3) && !$past(rst, 3)
    && !$past(rst, 1) && !$past(rst, 2)
    |-> held_power_cmd_n == $past(card_power_cmd_n, 3)) else $error("stale");
a_link_track: assert property (!$past(rst, 3) && !$past(rst, 1)
    && !$past(rst, 2) |->
    host_link_enable == !$past(select_n, 3)) else $error("link");
a_reset_idle: assert property ($fell(rst) |->
    !card_supply && host_io_pullup_oe) else $error("idle");
a_power_on: assert property ($fell(held_power_cmd_n) |=>
    card_supply && !host_io_pullup_oe) else $error("on");
a_power_off: assert property ($rose(held_power_cmd_n) |=>
    !card_supply && host_io_pullup_oe) else $error("off");
cover property ($rose(card_supply));
cover property ($fell(card_supply));
cover property (select_n[*4]);
endmodule
bind cisl_select_latch cisl_checker cisl_checker_inst (.*);
`default_nettype wire

// >>> tb/cisl_host_model.sv
// Host line model
`timescale 1ns/1ps
`default_nettype none
module cisl_host_model (input wire logic supply_on, want, output logic drv);
// Host drives its line only once it sees the card supply on
assign drv = want && supply_on;
endmodule
`default_nettype wire

// >>> tb/test_cisl_select_latch.sv
// Select latch bench
`timescale 1ns/1ps
`default_nettype none
module test_cisl_select_latch;
logic clk = 0, rst = 1;
logic [6:0] v = 7'h20;
logic [5:0] e = 6'h20;
wire [10:0] y;
wire drv;
int num_errors = 0, n_tests = 0;
cisl_select_latch cisl_select_latch_inst (.clk(clk), .rst(rst),
    .select_n(v[6]), .card_power_cmd_n(v[5]), .supply_voltage_sel0(v[4]),
    .supply_voltage_sel1(v[3]), .clock_ratio_sel1(v[2]),
    .clock_ratio_sel2(v[1]), .host_card_reset_in(v[0]),
    .held_power_cmd_n(y[10]), .held_voltage_sel0(y[9]),
    .held_voltage_sel1(y[8]), .held_ratio_sel1(y[7]), .held_ratio_sel2(y[6]),
    .held_card_reset(y[5]), .card_supply(y[4]), .host_io_pullup_oe(y[3]),
    .host_aux_line1_pullup_oe(y[2]), .host_aux_line2_pullup_oe(y[1]),
    .host_link_enable(y[0]));
cisl_host_model cisl_host_model_inst (.supply_on(y[4]), .want(v[0]),
    .drv(drv));
// Held copy, supply and pull-ups from the held pins, link from the select pin
function logic [10:0] expect_y(logic [5:0] h, logic s);
    return {h, !h[5], {3{h[5]}}, !s};
endfunction
task chk(string n, logic [10:0] x, logic [10:0] g);
    n_tests++;
    if (g !== x) $display("MISMATCH %s exp %h got %h", n, x, g);
    num_errors += int'(g !== x);
endtask
task end_of_test;
    $display("%0d checks %0d mismatches", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
endtask
initial forever #50 clk = ~clk;
// Power on, deselect with a command change, then random pins
initial begin
    void'($urandom(32'h9E636757));
    repeat (16) @(posedge clk);
    #5 chk("reset", expect_y(e, 1'b1), y);
    $display("reset test done");
    rst = 0;
    for (int i = 0; i < 64; i++) begin
        v = i == 0 ? 7'h00 : i == 1 ? 7'h7F : 7'($urandom);
        e = v[6] ? e : v[5:0];
        repeat (5) @(posedge clk);
        #5 chk("outputs", expect_y(e, v[6]), y);
        chk("clash", 11'h0, {10'h0, drv & y[3]});
    end
    $display("sequence done");
    // Reset in mid-run, then select and power the card again
    v = 7'h00;
    rst = 1;
    repeat (3) @(posedge clk);
    #5 chk("rerun reset", expect_y(6'h20, 1'b1), y);
    rst = 0;
    repeat (5) @(posedge clk);
    #5 chk("rerun power", expect_y(6'h00, 1'b0), y);
    $display("mid-run reset done");
    end_of_test;
end
endmodule
`default_nettype wire
